// ===== rtl/mpc_pkg.sv
// Shared constants and carriers for the maintenance phase and address compare block.
package mpc_pkg;
  localparam int unsigned MPC_ADDR_W = 16;
  localparam int unsigned MPC_PHASES = 4;
  localparam logic [3:0] MPC_PH1 = 4'h1;
  localparam logic [3:0] MPC_PH2 = 4'h2;
  localparam logic [3:0] MPC_PH3 = 4'h4;
  localparam logic [3:0] MPC_PH4 = 4'h8;
  localparam logic [3:0] MPC_PH_RESET = 4'h0;
  localparam logic [2:0] MPC_CNT_RESET = 3'h0;
  localparam logic [2:0] MPC_CYCLE_LAST = 3'h3;

  typedef enum logic [3:0] {
    MPC_MODE_NORMAL = 4'h1,
    MPC_MODE_PHASE = 4'h2,
    MPC_MODE_CYCLE = 4'h4,
    MPC_MODE_INST = 4'h8
  } mpc_mode_t;

  typedef enum logic [2:0] {
    MPC_ST_RUN = 3'h1,
    MPC_ST_STEP = 3'h2,
    MPC_ST_HALT = 3'h4
  } mpc_state_t;

  typedef struct packed {
    logic [MPC_ADDR_W-1:0] addr;
    logic read;
    logic write;
  } mpc_stor_t;

  typedef struct packed {
    mpc_state_t st;
    mpc_mode_t mode;
    logic [3:0] phase;
    logic [2:0] cnt;
    logic hit;
    logic pend_stop;
    logic stopped;
    logic timer_en;
    logic clear_stor;
  } mpc_reg_t;
endpackage

// ===== rtl/mpc_compare.sv
// Address comparator for the maintenance panel compare switches.
module mpc_compare import mpc_pkg::*; #(
  parameter int unsigned ADDR_W = MPC_ADDR_W
) (
  // Switch and storage addresses.
  input wire logic [ADDR_W-1:0] i_switch_addr,
  input wire logic [ADDR_W-1:0] i_stor_addr,
  // Match result.
  output logic o_match
);
  // All bits take part; a partial compare would give false halts.
  assign o_match = (i_switch_addr == i_stor_addr);
endmodule

// ===== rtl/mpc_maint.sv
// Maintenance panel phase register, stop on address compare and timer inhibit.
module mpc_maint import mpc_pkg::*; (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Panel mode and phase controls.
  input wire logic i_sel_normal,
  input wire logic i_sel_phase,
  input wire logic i_sel_cycle,
  input wire logic i_sel_inst,
  input wire logic [3:0] i_phase_set,
  input wire logic i_phase_clear,
  input wire logic i_phase_hold,
  input wire logic i_run,
  input wire logic i_stop,
  // Compare switches, bit 0 is switch 30.
  input wire logic [MPC_ADDR_W-1:0] i_cmp_switch,
  input wire logic i_read_stop_en,
  input wire logic i_write_stop_en,
  // Processor storage path.
  input wire mpc_stor_t i_stor,
  input wire logic i_inst_end,
  // Timer and initial load.
  input wire logic i_timer_inhibit,
  input wire logic i_initial_program_load,
  // Outputs.
  output logic [3:0] o_phase,
  output logic o_phase_pulse,
  output logic o_hold_error,
  output logic [MPC_ADDR_W-1:0] o_cmp_addr,
  output logic o_cmp_hit,
  output logic o_stopped,
  output logic o_timer_update_en,
  output logic o_clear_storage
);
  mpc_reg_t r;
  mpc_reg_t next_r;
  logic match;
  logic stop_hit;
  logic panel_idle;

  function automatic logic one_hot4(input logic [3:0] v);
    one_hot4 = (v == MPC_PH1) || (v == MPC_PH2) || (v == MPC_PH3) || (v == MPC_PH4);
  endfunction

  function automatic logic [3:0] next_phase(input logic [3:0] v);
    case (v)
      MPC_PH4: next_phase = MPC_PH1;
      MPC_PH1: next_phase = MPC_PH2;
      MPC_PH2: next_phase = MPC_PH3;
      default: next_phase = MPC_PH4;
    endcase
  endfunction

  mpc_compare #(.ADDR_W(MPC_ADDR_W)) mpc_compare_inst (
    .i_switch_addr(i_cmp_switch),
    .i_stor_addr(i_stor.addr),
    .o_match(match)
  );

  assign stop_hit = match && ((i_stor.read && i_read_stop_en) ||
                              (i_stor.write && i_write_stop_en));
  assign panel_idle = !i_sel_phase && !i_sel_cycle && !i_sel_inst && !i_sel_normal &&
                      !i_phase_clear && (i_phase_set == 4'h0);

  always_comb begin
    next_r = r;
    next_r.hit = match;
    if (i_sel_phase) begin
      next_r.mode = MPC_MODE_PHASE;
      next_r.phase = MPC_PH4;
      next_r.st = MPC_ST_HALT;
    end else if (i_sel_cycle) begin
      next_r.mode = MPC_MODE_CYCLE;
      next_r.phase = MPC_PH4;
      next_r.st = MPC_ST_HALT;
    end else if (i_sel_inst) begin
      next_r.mode = MPC_MODE_INST;
    end else if (i_sel_normal) begin
      next_r.mode = MPC_MODE_NORMAL;
    end else if (i_phase_clear && (r.mode == MPC_MODE_PHASE || r.mode == MPC_MODE_CYCLE)) begin
      next_r.phase = MPC_PH_RESET;
      next_r.st = MPC_ST_HALT;
    end else if (|i_phase_set) begin
      // Panel may set any bit; in phase or cycle mode the clear control undoes a wrong choice.
      next_r.phase = r.phase | i_phase_set;
    end else begin
      case (r.st)
        MPC_ST_HALT: begin
          if (i_run && r.mode == MPC_MODE_PHASE) begin
            next_r.st = MPC_ST_STEP;
          end else if (i_run && r.mode == MPC_MODE_CYCLE) begin
            next_r.st = MPC_ST_STEP;
            next_r.cnt = MPC_CNT_RESET;
          end
        end
        MPC_ST_STEP: begin
          if (r.mode == MPC_MODE_CYCLE) begin
            next_r.phase = next_phase(r.phase);
            next_r.cnt = r.cnt + 3'h1;
            if (r.cnt == MPC_CYCLE_LAST) begin
              next_r.st = MPC_ST_HALT;
              next_r.phase = MPC_PH4;
            end
          end else if (!(i_phase_hold && one_hot4(r.phase))) begin
            next_r.phase = next_phase(r.phase);
            next_r.st = MPC_ST_HALT;
          end
        end
        default: next_r.st = MPC_ST_HALT;
      endcase
    end
    // The request is latched so a stop is never lost before the instruction ends.
    // A request seen at the instruction end stops at once, so nothing stays pending.
    if (i_inst_end) begin
      next_r.pend_stop = 1'b0;
    end else if (stop_hit || i_stop) begin
      next_r.pend_stop = 1'b1;
    end
    if (i_inst_end && (r.pend_stop || stop_hit || i_stop)) begin
      next_r.stopped = 1'b1;
    end else if (i_run && !stop_hit) begin
      next_r.stopped = 1'b0;
    end
    next_r.timer_en = !i_timer_inhibit && !i_initial_program_load;
    next_r.clear_stor = i_initial_program_load;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      r <= '{st: MPC_ST_HALT, mode: MPC_MODE_NORMAL, phase: MPC_PH_RESET,
             cnt: MPC_CNT_RESET, default: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign o_phase = r.phase;
  assign o_phase_pulse = (r.st == MPC_ST_STEP);
  assign o_hold_error = i_phase_hold && !one_hot4(r.phase);
  assign o_cmp_addr = i_cmp_switch;
  assign o_cmp_hit = r.hit;
  assign o_stopped = r.stopped;
  assign o_timer_update_en = r.timer_en;
  assign o_clear_storage = r.clear_stor;

  chk_timer_inhibit: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_timer_inhibit || i_initial_program_load) |=> !o_timer_update_en)
    else $error("Timer updated while inhibited.");
  chk_load_timer: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_initial_program_load |=> !o_timer_update_en && o_clear_storage)
    else $error("Initial load did not suppress timer or clear storage.");
  chk_mode_phase4: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_sel_phase || i_sel_cycle) |=> o_phase == MPC_PH4)
    else $error("Mode entry did not select phase 4.");
  chk_phase_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_phase_clear && !i_sel_phase && !i_sel_cycle && !i_sel_inst && !i_sel_normal &&
     (r.mode == MPC_MODE_PHASE || r.mode == MPC_MODE_CYCLE)) |=> o_phase == MPC_PH_RESET)
    else $error("Phase clear failed.");
  chk_hit_equal: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_cmp_hit == (($past(i_cmp_switch)) == $past(i_stor.addr)))
    else $error("Compare hit wrong.");
  chk_read_stop: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (match && i_stor.read && i_read_stop_en && i_inst_end) |=> o_stopped)
    else $error("Read compare did not stop.");
  chk_write_stop: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (match && i_stor.write && i_write_stop_en && i_inst_end) |=> o_stopped)
    else $error("Write compare did not stop.");
  chk_stop_at_end: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!o_stopped && !i_inst_end) |=> !o_stopped)
    else $error("Stop before instruction end.");
  chk_cycle_order: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (r.mode == MPC_MODE_CYCLE && r.st == MPC_ST_STEP && o_phase == MPC_PH4 &&
     !i_sel_phase && !i_sel_cycle && !i_sel_inst && !i_sel_normal && !i_phase_clear &&
     i_phase_set == 4'h0) |=> o_phase == MPC_PH1)
    else $error("Cycle order wrong.");
  chk_hold_repeat: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (r.st == MPC_ST_STEP && r.mode == MPC_MODE_PHASE && i_phase_hold && one_hot4(r.phase) &&
     panel_idle) |=> o_phase_pulse && $stable(o_phase))
    else $error("Held phase was not repeated.");
  chk_phase_single: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (r.st == MPC_ST_STEP && r.mode == MPC_MODE_PHASE && !i_phase_hold && panel_idle)
    |=> !o_phase_pulse)
    else $error("Phase mode gave more than one phase.");
  chk_run_start: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (r.st == MPC_ST_HALT && r.mode == MPC_MODE_CYCLE && i_run && panel_idle) |=> o_phase_pulse)
    else $error("Cycle run did not start.");
  chk_cycle_end: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (r.st == MPC_ST_STEP && r.mode == MPC_MODE_CYCLE && r.cnt == MPC_CYCLE_LAST && panel_idle)
    |=> !o_phase_pulse && o_phase == MPC_PH4)
    else $error("Cycle did not end after four phases.");
  chk_stop_disabled: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!i_read_stop_en && !i_write_stop_en && !i_stop && !r.pend_stop && !o_stopped)
    |=> !o_stopped)
    else $error("Stop without an enabled request.");
  chk_load_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !i_initial_program_load |=> !o_clear_storage)
    else $error("Storage clear outside initial load.");
  cov_cycle_run: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    r.mode == MPC_MODE_CYCLE && o_phase_pulse);
  cov_read_halt: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    stop_hit && i_stor.read ##1 o_stopped);
  cov_hold: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    o_phase_pulse && i_phase_hold ##1 o_phase_pulse);
endmodule

// ===== tb/mpc_stor_model.sv
// Storage path model of the processor side: selectors, commands, instruction end.
module mpc_stor_model import mpc_pkg::*; (
  // Clock.
  input wire logic i_clock,
  // Commands from the bench.
  input wire logic [MPC_ADDR_W-1:0] i_cmd_addr,
  input wire logic i_cmd_read,
  input wire logic i_cmd_write,
  input wire logic i_end,
  // Storage path toward the block.
  output mpc_stor_t o_stor,
  output logic o_inst_end
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [MPC_ADDR_W-1:0] last_addr = 16'h0000;
  always_ff @(posedge i_clock) begin
    if (i_cmd_read || i_cmd_write) begin
      last_addr <= i_cmd_addr;
    end
  end
  // Idle selectors show the inverse of the last address, so a stale value never matches.
  always_comb begin
    o_stor.addr = (i_cmd_read || i_cmd_write) ? i_cmd_addr : ~last_addr;
    o_stor.read = i_cmd_read;
    o_stor.write = i_cmd_write;
    o_inst_end = i_end;
  end
endmodule

// ===== tb/mpc_maint_tb.sv
// Self-checking bench for the maintenance phase and address compare block.
module mpc_maint_tb import mpc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_sel_normal = 1'b0, i_sel_phase = 1'b0;
  logic i_sel_cycle = 1'b0, i_sel_inst = 1'b0, i_phase_clear = 1'b0, i_phase_hold = 1'b0;
  logic i_run = 1'b0, i_stop = 1'b0, i_read_stop_en = 1'b0, i_write_stop_en = 1'b0;
  logic cmd_rd = 1'b0, cmd_wr = 1'b0, end_req = 1'b0;
  logic i_timer_inhibit = 1'b0, i_initial_program_load = 1'b0;
  logic [3:0] i_phase_set = 4'h0;
  logic [15:0] i_cmp_switch = 16'ha5c3, cmd_addr = 16'h0000;
  logic [3:0] seq [4] = '{MPC_PH1, MPC_PH2, MPC_PH3, MPC_PH4};
  mpc_stor_t i_stor;
  logic i_inst_end, o_phase_pulse, o_hold_error, o_cmp_hit, o_stopped;
  logic o_timer_update_en, o_clear_storage;
  logic [3:0] o_phase;
  logic [15:0] o_cmp_addr;
  int fail_count = 0;
  int total_checks = 0;
  always #2.5 i_clock = ~i_clock;
  mpc_maint mpc_maint_inst (.i_clock, .i_rst_n, .i_sel_normal, .i_sel_phase, .i_sel_cycle,
    .i_sel_inst, .i_phase_set, .i_phase_clear, .i_phase_hold, .i_run, .i_stop, .i_cmp_switch,
    .i_read_stop_en, .i_write_stop_en, .i_stor, .i_inst_end, .i_timer_inhibit,
    .i_initial_program_load, .o_phase, .o_phase_pulse, .o_hold_error, .o_cmp_addr,
    .o_cmp_hit, .o_stopped, .o_timer_update_en, .o_clear_storage);
  mpc_stor_model mpc_stor_model_inst (.i_clock, .i_cmd_addr(cmd_addr), .i_cmd_read(cmd_rd),
    .i_cmd_write(cmd_wr), .i_end(end_req), .o_stor(i_stor), .o_inst_end(i_inst_end));
  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A stop waits for the instruction end, so the wait is bounded, not fixed.
  task automatic wait_stop();
    int k;
    k = 0;
    while (o_stopped !== 1'b1 && k < 8) begin
      step(1);
      k++;
    end
    if (o_stopped !== 1'b1) begin
      chkb(o_stopped, 1'b1);
      print_verdict();
    end
  endtask
  initial begin
    step(3);
    chkv({12'h000, o_phase}, 16'h0000);
    i_rst_n = 1'b1;
    step(2);
    chkb(o_timer_update_en, 1'b1);
    chkv(o_cmp_addr, 16'ha5c3);
    i_sel_cycle = 1'b1;
    step(1);
    i_sel_cycle = 1'b0;
    chkv({12'h000, o_phase}, {12'h000, MPC_PH4});
    i_run = 1'b1;
    step(1);
    i_run = 1'b0;
    chkb(o_phase_pulse, 1'b1);
    foreach (seq[i]) begin
      step(1);
      chkv({12'h000, o_phase}, {12'h000, seq[i]});
    end
    chkb(o_phase_pulse, 1'b0);
    i_phase_clear = 1'b1;
    step(1);
    i_phase_clear = 1'b0;
    chkv({12'h000, o_phase}, 16'h0000);
    i_sel_phase = 1'b1;
    step(1);
    i_sel_phase = 1'b0;
    i_run = 1'b1;
    step(1);
    i_run = 1'b0;
    chkb(o_phase_pulse, 1'b1);
    step(1);
    chkv({12'h000, o_phase}, {12'h000, MPC_PH1});
    i_phase_hold = 1'b1;
    i_run = 1'b1;
    step(1);
    i_run = 1'b0;
    chkb(o_hold_error, 1'b0);
    step(2);
    chkb(o_phase_pulse, 1'b1);
    chkv({12'h000, o_phase}, {12'h000, MPC_PH1});
    i_phase_clear = 1'b1;
    step(1);
    i_phase_clear = 1'b0;
    chkb(o_hold_error, 1'b1);
    i_phase_set = MPC_PH3;
    step(1);
    i_phase_set = 4'h0;
    chkv({12'h000, o_phase}, {12'h000, MPC_PH3});
    chkb(o_hold_error, 1'b0);
    i_phase_hold = 1'b0;
    i_sel_normal = 1'b1;
    cmd_addr = 16'ha5c3;
    cmd_rd = 1'b1;
    step(1);
    i_sel_normal = 1'b0;
    chkb(o_cmp_hit, 1'b1);
    cmd_addr = 16'h25c3;
    step(1);
    chkb(o_cmp_hit, 1'b0);
    i_read_stop_en = 1'b1;
    cmd_addr = 16'ha5c3;
    step(2);
    chkb(o_stopped, 1'b0);
    end_req = 1'b1;
    step(1);
    end_req = 1'b0;
    cmd_rd = 1'b0;
    wait_stop();
    chkb(o_stopped, 1'b1);
    i_read_stop_en = 1'b0;
    i_run = 1'b1;
    step(1);
    i_run = 1'b0;
    cmd_wr = 1'b1;
    end_req = 1'b1;
    step(3);
    chkb(o_stopped, 1'b0);
    i_write_stop_en = 1'b1;
    wait_stop();
    chkb(o_stopped, 1'b1);
    cmd_wr = 1'b0;
    end_req = 1'b0;
    i_timer_inhibit = 1'b1;
    step(1);
    chkb(o_timer_update_en, 1'b0);
    i_timer_inhibit = 1'b0;
    i_initial_program_load = 1'b1;
    step(1);
    chkb(o_timer_update_en, 1'b0);
    chkb(o_clear_storage, 1'b1);
    i_initial_program_load = 1'b0;
    step(1);
    chkb(o_clear_storage, 1'b0);
    i_sel_inst = 1'b1;
    step(1);
    i_sel_inst = 1'b0;
    i_run = 1'b1;
    step(1);
    i_run = 1'b0;
    chkb(o_phase_pulse, 1'b0);
    chkb(o_stopped, 1'b0);
    // Manual storage clear; the operator's long run is cut to one reset cycle here.
    i_rst_n = 1'b0;
    step(1);
    i_rst_n = 1'b1;
    chkb(o_timer_update_en, 1'b0);
    chkv({12'h000, o_phase}, 16'h0000);
    i_write_stop_en = 1'b0;
    cmd_addr = 16'h1234;
    cmd_wr = 1'b1;
    i_sel_normal = 1'b1;
    step(1);
    i_sel_normal = 1'b0;
    i_run = 1'b1;
    step(1);
    i_run = 1'b0;
    step(3);
    chkb(o_stopped, 1'b0);
    i_stop = 1'b1;
    step(1);
    i_stop = 1'b0;
    chkb(o_stopped, 1'b0);
    end_req = 1'b1;
    step(1);
    end_req = 1'b0;
    chkb(o_stopped, 1'b1);
    i_rst_n = 1'b0;
    cmd_wr = 1'b0;
    step(1);
    i_rst_n = 1'b1;
    chkb(o_stopped, 1'b0);
    print_verdict();
  end
endmodule
